// ==== hw/eps_seq.sv ====
// Purpose: Host-side programming sequencer for a 32K x 8 UV-erasable EPROM.
// Assumes: User supplies the expected byte for each address on request.
// Notes: Each pass re-requests bytes, so the user must replay the same data.
module eps_seq #(
  parameter int FAST_PULSE = eps_pkg::FAST_PULSE_CYC,
  parameter int INTER_PULSE = eps_pkg::INTER_PULSE_CYC,
  parameter int FAST_MAX = eps_pkg::FAST_MAX_PULSES,
  parameter int INTER_MAX = eps_pkg::INTER_MAX_PULSES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire eps_pkg::eps_cmd_t cmd,
  input wire logic byteValid,
  input wire logic [eps_pkg::DATA_W-1:0] byteIn,
  input wire logic [eps_pkg::DATA_W-1:0] dataIn,
  output eps_pkg::eps_pins_t pins,
  output logic wantByte,
  output logic [eps_pkg::ADDR_W-1:0] wantAddr,
  output logic busy,
  output logic done,
  output logic failPulse,
  output logic [eps_pkg::ADDR_W-1:0] failAddr,
  output logic anyFail
);
  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  localparam logic [eps_pkg::TMR_W-1:0] T_SETTLE = eps_pkg::TMR_W'(eps_pkg::SETTLE_CYC);
  localparam logic [eps_pkg::TMR_W-1:0] T_SETUP = eps_pkg::TMR_W'(eps_pkg::SETUP_CYC);
  localparam logic [eps_pkg::TMR_W-1:0] T_HOLD = eps_pkg::TMR_W'(eps_pkg::HOLD_CYC);
  localparam logic [eps_pkg::TMR_W-1:0] T_READ = eps_pkg::TMR_W'(eps_pkg::READ_CYC);
  localparam logic [eps_pkg::TMR_W-1:0] T_FPULSE = eps_pkg::TMR_W'(FAST_PULSE);
  localparam logic [eps_pkg::TMR_W-1:0] T_IPULSE = eps_pkg::TMR_W'(INTER_PULSE);
  localparam logic [eps_pkg::CNT_W-1:0] N_FAST = eps_pkg::CNT_W'(FAST_MAX);
  localparam logic [eps_pkg::CNT_W-1:0] N_INTER = eps_pkg::CNT_W'(INTER_MAX);

  eps_pkg::eps_state_t state_reg;
  eps_pkg::eps_pass_t pass_reg;
  logic [eps_pkg::TMR_W-1:0] tmr_reg;
  logic [eps_pkg::CNT_W-1:0] pulses_reg;
  logic [eps_pkg::DATA_W-1:0] expect_reg;
  logic fast_reg;
  logic [eps_pkg::ADDR_W-1:0] first_reg;
  logic [eps_pkg::ADDR_W-1:0] last_reg;
  logic [eps_pkg::DATA_W-1:0] readBack;
  logic tmrDone;
  logic isMatch;
  logic atLimit;
  logic atLast;
  logic [eps_pkg::TMR_W-1:0] pulseWidth;
  logic [eps_pkg::CNT_W-1:0] pulseMax;
  logic [eps_pkg::ADDR_W-1:0] addrInc;

  eps_sync #(.W(eps_pkg::DATA_W)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn(dataIn),
    .stableOut(readBack)
  );

  // -------------------------------------------------------------------
  // Decoding
  // -------------------------------------------------------------------
  assign tmrDone = (tmr_reg == '0);
  assign isMatch = (readBack == expect_reg);
  assign pulseWidth = fast_reg ? T_FPULSE : T_IPULSE;
  assign pulseMax = fast_reg ? N_FAST : N_INTER;
  assign atLimit = (pulses_reg >= pulseMax);
  assign atLast = (pins.addrLines == last_reg);
  assign addrInc = pins.addrLines + 15'h0001;

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= eps_pkg::ST_IDLE;
      pass_reg <= eps_pkg::PASS_PROG;
      tmr_reg <= '0;
      pulses_reg <= '0;
      expect_reg <= 8'hff;
      fast_reg <= 1'b0;
      first_reg <= '0;
      last_reg <= '0;
      pins <= '{addrLines: '0, dataOut: 8'hff, dataOe: 1'b0, selN: 1'b1,
                gateN: 1'b1, vppSel: eps_pkg::VPP_NOM, vccSel: eps_pkg::VCC_NOM};
      wantByte <= 1'b0;
      wantAddr <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      failPulse <= 1'b0;
      failAddr <= '0;
      anyFail <= 1'b0;
    end else begin
      done <= 1'b0;
      failPulse <= 1'b0;
      if (!tmrDone) begin
        tmr_reg <= tmr_reg - 16'h0001;
      end
      case (state_reg)
        eps_pkg::ST_IDLE: begin
          pins.selN <= 1'b1;
          if (cmd.start) begin
            fast_reg <= cmd.fast;
            first_reg <= cmd.first;
            last_reg <= cmd.last;
            pins.addrLines <= cmd.first;
            pass_reg <= eps_pkg::PASS_PROG;
            anyFail <= 1'b0;
            busy <= 1'b1;
            pins.gateN <= 1'b1;
            pins.vppSel <= cmd.fast ? eps_pkg::VPP_FAST : eps_pkg::VPP_PROG;
            pins.vccSel <= cmd.fast ? eps_pkg::VCC_FAST : eps_pkg::VCC_RAISED;
            tmr_reg <= T_SETTLE;
            state_reg <= eps_pkg::ST_SUPPLY;
          end
        end
        eps_pkg::ST_SUPPLY: begin
          if (tmrDone) begin
            wantByte <= 1'b1;
            wantAddr <= pins.addrLines;
            state_reg <= eps_pkg::ST_LOAD;
          end
        end
        eps_pkg::ST_LOAD: begin
          if (byteValid) begin
            wantByte <= 1'b0;
            expect_reg <= byteIn;
            pulses_reg <= '0;
            if (pass_reg == eps_pkg::PASS_FINAL) begin
              // Fast mode reads back in plain read mode, supplies nominal
              pins.selN <= !fast_reg;
              pins.gateN <= 1'b0;
              tmr_reg <= T_READ;
              state_reg <= eps_pkg::ST_VERIFY;
            end else begin
              pins.dataOut <= byteIn;
              pins.dataOe <= 1'b1;
              tmr_reg <= T_SETUP;
              state_reg <= eps_pkg::ST_SETUP;
            end
          end
        end
        eps_pkg::ST_SETUP: begin
          if (tmrDone) begin
            pins.selN <= 1'b0;
            tmr_reg <= pulseWidth;
            pulses_reg <= pulses_reg + 6'h01;
            state_reg <= eps_pkg::ST_PULSE;
          end
        end
        eps_pkg::ST_PULSE: begin
          if (tmrDone) begin
            pins.selN <= 1'b1;
            tmr_reg <= T_HOLD;
            state_reg <= eps_pkg::ST_HOLD;
          end
        end
        eps_pkg::ST_HOLD: begin
          if (tmrDone) begin
            pins.dataOe <= 1'b0;
            if (pass_reg == eps_pkg::PASS_OVER) begin
              state_reg <= eps_pkg::ST_NEXT;
            end else begin
              // Gate drops one cycle after release to avoid bus fight
              tmr_reg <= T_READ;
              state_reg <= eps_pkg::ST_VERIFY;
            end
          end
        end
        eps_pkg::ST_VERIFY: begin
          if (pins.dataOe == 1'b0 && pass_reg != eps_pkg::PASS_FINAL) begin
            pins.gateN <= 1'b0;
          end
          if (tmrDone) begin
            pins.gateN <= 1'b1;
            pins.selN <= 1'b1;
            if (pass_reg == eps_pkg::PASS_FINAL) begin
              if (!isMatch) begin
                failPulse <= 1'b1;
                failAddr <= pins.addrLines;
                anyFail <= 1'b1;
              end
              state_reg <= eps_pkg::ST_NEXT;
            end else if (isMatch) begin
              state_reg <= eps_pkg::ST_NEXT;
            end else if (atLimit) begin
              failPulse <= 1'b1;
              failAddr <= pins.addrLines;
              anyFail <= 1'b1;
              state_reg <= eps_pkg::ST_NEXT;
            end else begin
              pins.dataOe <= 1'b1;
              tmr_reg <= T_SETUP;
              state_reg <= eps_pkg::ST_SETUP;
            end
          end
        end
        eps_pkg::ST_NEXT: begin
          if (!atLast) begin
            pins.addrLines <= addrInc;
            wantByte <= 1'b1;
            wantAddr <= addrInc;
            state_reg <= eps_pkg::ST_LOAD;
          end else if (pass_reg == eps_pkg::PASS_PROG && !fast_reg) begin
            pass_reg <= eps_pkg::PASS_OVER;
            pins.addrLines <= first_reg;
            wantByte <= 1'b1;
            wantAddr <= first_reg;
            state_reg <= eps_pkg::ST_LOAD;
          end else if (pass_reg != eps_pkg::PASS_FINAL) begin
            pass_reg <= eps_pkg::PASS_FINAL;
            pins.addrLines <= first_reg;
            pins.vccSel <= eps_pkg::VCC_NOM;
            pins.vppSel <= fast_reg ? eps_pkg::VPP_NOM : eps_pkg::VPP_PROG;
            tmr_reg <= T_SETTLE;
            state_reg <= eps_pkg::ST_SUPPLY;
          end else begin
            pins.vppSel <= eps_pkg::VPP_NOM;
            pins.vccSel <= eps_pkg::VCC_NOM;
            state_reg <= eps_pkg::ST_DONE;
          end
        end
        eps_pkg::ST_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          state_reg <= eps_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= eps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  logic [eps_pkg::TMR_W-1:0] lowCnt;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lowCnt <= '0;
    end else begin
      lowCnt <= (!pins.selN && pins.gateN) ? lowCnt + 16'h0001 : '0;
    end
  end

  sequence s_pulseStart;
    $fell(pins.selN) && pins.gateN;
  endsequence
  sequence s_progReady;
    pins.vppSel != eps_pkg::VPP_NOM && $past(pins.dataOe) && $stable(pins.addrLines);
  endsequence

  property p_progEntry;
    @(posedge mclk) disable iff (!nrst) s_pulseStart |-> s_progReady;
  endproperty
  a_progEntry: assert property (p_progEntry) else $error("pulse outside program mode");

  property p_dataStable;
    @(posedge mclk) disable iff (!nrst)
      s_pulseStart |-> pins.dataOe && $stable(pins.dataOut) ##1 $stable(pins.dataOut);
  endproperty
  a_dataStable: assert property (p_dataStable) else $error("data moved at pulse");

  property p_pulseWidth;
    @(posedge mclk) disable iff (!nrst)
      $rose(pins.selN) && $past(pins.gateN) && $past(!pins.selN) |->
      lowCnt == pulseWidth + 16'h0001 && $past(lowCnt) == pulseWidth;
  endproperty
  a_pulseWidth: assert property (p_pulseWidth) else $error("pulse width wrong");

  property p_fastSupply;
    @(posedge mclk) disable iff (!nrst)
      state_reg == eps_pkg::ST_PULSE && fast_reg |->
      pins.vppSel == eps_pkg::VPP_FAST && pins.vccSel == eps_pkg::VCC_FAST;
  endproperty
  a_fastSupply: assert property (p_fastSupply) else $error("fast supplies wrong");

  property p_interSupply;
    @(posedge mclk) disable iff (!nrst)
      state_reg == eps_pkg::ST_PULSE && !fast_reg |-> pins.vccSel == eps_pkg::VCC_RAISED;
  endproperty
  a_interSupply: assert property (p_interSupply) else $error("main supply not raised");

  property p_pulseLimit;
    @(posedge mclk) disable iff (!nrst) pulses_reg <= pulseMax;
  endproperty
  a_pulseLimit: assert property (p_pulseLimit) else $error("too many pulses");

  property p_finalNominal;
    @(posedge mclk) disable iff (!nrst)
      state_reg == eps_pkg::ST_VERIFY && pass_reg == eps_pkg::PASS_FINAL |->
      pins.vccSel == eps_pkg::VCC_NOM && (!fast_reg || pins.vppSel == eps_pkg::VPP_NOM);
  endproperty
  a_finalNominal: assert property (p_finalNominal) else $error("final verify off nominal");

  property p_noFight;
    @(posedge mclk) disable iff (!nrst) !pins.gateN |-> !pins.dataOe;
  endproperty
  a_noFight: assert property (p_noFight) else $error("bus driven during read");

  property p_failReport;
    @(posedge mclk) disable iff (!nrst)
      failPulse |-> $past(state_reg) == eps_pkg::ST_VERIFY && state_reg == eps_pkg::ST_NEXT;
  endproperty
  a_failReport: assert property (p_failReport) else $error("fail out of place");
endmodule

// ==== hw/eps_pkg.sv ====
// Purpose: Shared constants and types for the EPROM programming sequencer.
// Assumes: 100 MHz mclk; supply levels are selected by external regulators.
// Notes: Supply select codes drive off-chip level switches.
package eps_pkg;
  // -------------------------------------------------------------------
  // Widths and timing
  // -------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int TMR_W = 16;
  localparam int CNT_W = 6;
  localparam int CLK_MHZ = 100;
  localparam int FAST_PULSE_US = 100;
  localparam int FAST_PULSE_CYC = FAST_PULSE_US * CLK_MHZ;
  localparam int INTER_PULSE_US = 100;
  localparam int INTER_PULSE_CYC = INTER_PULSE_US * CLK_MHZ;
  localparam int FAST_MAX_PULSES = 25;
  localparam int INTER_MAX_PULSES = 25;
  localparam int SETTLE_US = 2;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int SETUP_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_NS = 100;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_NS = 250;
  localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
  // -------------------------------------------------------------------
  // Supply select codes
  // -------------------------------------------------------------------
  localparam logic [1:0] VPP_NOM = 2'h0;
  localparam logic [1:0] VPP_PROG = 2'h1;
  localparam logic [1:0] VPP_FAST = 2'h2;
  localparam logic [1:0] VCC_NOM = 2'h0;
  localparam logic [1:0] VCC_RAISED = 2'h1;
  localparam logic [1:0] VCC_FAST = 2'h2;
  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SUPPLY = 4'h1,
    ST_LOAD = 4'h3,
    ST_SETUP = 4'h2,
    ST_PULSE = 4'h6,
    ST_HOLD = 4'h7,
    ST_VERIFY = 4'h5,
    ST_NEXT = 4'h4,
    ST_DONE = 4'hc
  } eps_state_t;
  typedef enum logic [1:0] {
    PASS_PROG = 2'h0,
    PASS_OVER = 2'h1,
    PASS_FINAL = 2'h3
  } eps_pass_t;
  typedef struct packed {
    logic start;
    logic fast;
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
  } eps_cmd_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addrLines;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
    // Only the select strobe is per part; gate and the rest may fan out
    logic selN;
    logic gateN;
    logic [1:0] vppSel;
    logic [1:0] vccSel;
  } eps_pins_t;
endpackage

// ==== hw/eps_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to mclk.
// Notes: Output moves only when stages two and three agree.
module eps_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] stableOut
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_next;

  assign stable_next = (s2_reg == s3_reg) ? s3_reg : stableOut;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stableOut <= '0;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stableOut <= stable_next;
    end
  end
endmodule

// ==== dv/eps_eprom_model.sv ====
// Purpose: Behavioural model of the 32K x 8 UV-erasable memory on the far side.
// Assumes: Pins come straight from the sequencer; supplies are the select codes.
// Notes: Cells may need several pulses before they take; released lines toggle.
module eps_eprom_model (
  input wire logic mclk,
  input wire eps_pkg::eps_pins_t pins,
  input wire logic [7:0] needPulses,
  output logic [eps_pkg::DATA_W-1:0] dataIn
);
  logic [eps_pkg::DATA_W-1:0] mem [0:(1 << eps_pkg::ADDR_W)-1];
  logic [eps_pkg::DATA_W-1:0] idleBus;
  logic [eps_pkg::ADDR_W-1:0] lastAddr;
  logic [7:0] hits;
  logic readOut;
  logic progMode;
  initial begin
    for (int i = 0; i < (1 << eps_pkg::ADDR_W); i++) begin
      mem[i] = 8'hff;
    end
    idleBus = 8'h00;
    lastAddr = '0;
    hits = 8'h00;
  end
  assign progMode = (pins.vppSel != eps_pkg::VPP_NOM) && pins.gateN;
  assign readOut = !pins.gateN && (!pins.selN || pins.vppSel != eps_pkg::VPP_NOM);
  // Released lines must not keep the last byte, or a stale read could pass
  assign dataIn = pins.dataOe ? pins.dataOut : (readOut ? mem[pins.addrLines] : ~idleBus);
  always @(posedge mclk) begin
    idleBus <= readOut ? mem[pins.addrLines] : ~idleBus;
  end
  // Write lands at the end of a select pulse
  always @(posedge pins.selN) begin
    if (progMode === 1'b1) begin
      hits = (pins.addrLines == lastAddr) ? hits + 8'h01 : 8'h01;
      lastAddr = pins.addrLines;
      if (hits >= needPulses) begin
        mem[pins.addrLines] = mem[pins.addrLines] & dataIn;
      end
    end
  end
endmodule

// ==== dv/eps_seq_tb.sv ====
// Purpose: Self-checking bench for the programming sequencer.
// Assumes: Pulse width shortened to 20 cycles; settle count as in the package.
// Notes: A second model with select held high stands for a ganged, inhibited part.
module eps_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 20;
  localparam int MAXP = eps_pkg::FAST_MAX_PULSES;
  localparam int LIMIT = 40000;
  logic mclk;
  logic nrst;
  eps_pkg::eps_cmd_t cmd;
  logic byteValid;
  logic [7:0] byteIn;
  logic [7:0] dataIn;
  eps_pkg::eps_pins_t pins;
  eps_pkg::eps_pins_t inhPins;
  logic wantByte;
  logic [14:0] wantAddr;
  logic [14:0] failAddr;
  logic [14:0] firstFail;
  logic busy;
  logic done;
  logic failPulse;
  logic anyFail;
  logic fastMode;
  logic prevGate = 1'b1;
  logic [7:0] needPulses;
  logic [7:0] expMem [0:32767];
  int numErrors;
  int checkCount;
  int cycles;
  int pulseCnt;
  int pulseLen;
  int readNom;
  int readRaised;
  int failCnt;
  // -------------------------------------------------------------------
  // Design and far side
  // -------------------------------------------------------------------
  eps_seq #(.FAST_PULSE(PW), .INTER_PULSE(PW), .FAST_MAX(MAXP), .INTER_MAX(MAXP)) dut_u (
    .mclk(mclk), .nrst(nrst), .cmd(cmd), .byteValid(byteValid), .byteIn(byteIn),
    .dataIn(dataIn), .pins(pins), .wantByte(wantByte), .wantAddr(wantAddr), .busy(busy),
    .done(done), .failPulse(failPulse), .failAddr(failAddr), .anyFail(anyFail));
  eps_eprom_model devU (.mclk(mclk), .pins(pins), .needPulses(needPulses), .dataIn(dataIn));
  always_comb begin
    inhPins = pins;
    inhPins.selN = 1'b1;
  end
  eps_eprom_model inhU (.mclk(mclk), .pins(inhPins), .needPulses(needPulses), .dataIn());
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // -------------------------------------------------------------------
  // Byte feeder, monitor, timeout
  // -------------------------------------------------------------------
  always @(posedge mclk) begin
    #1;
    byteValid = wantByte;
    byteIn = expMem[wantAddr];
  end
  always @(posedge mclk) begin
    if (failPulse === 1'b1) begin
      if (failCnt == 0) firstFail = failAddr;
      failCnt++;
    end
    if (prevGate === 1'b1 && pins.gateN === 1'b0) begin
      if (pins.vccSel === eps_pkg::VCC_NOM) readNom++;
      else readRaised++;
      if (fastMode && pins.vccSel === eps_pkg::VCC_NOM) check("final vpp", pins.vppSel, 0);
      if (!fastMode) check("verify vpp", pins.vppSel, eps_pkg::VPP_PROG);
      check("verify sel", pins.selN,
            (fastMode && pins.vccSel === eps_pkg::VCC_NOM) ? 1'b0 : 1'b1);
      if (!fastMode && pins.vccSel !== eps_pkg::VCC_NOM) begin
        check("verify vcc", pins.vccSel, eps_pkg::VCC_RAISED);
      end
    end
    prevGate = pins.gateN;
    if (pins.selN === 1'b0 && pins.gateN === 1'b1) begin
      pulseLen++;
      if (pulseLen == 1) begin
        check("pulse data", pins.dataOut, expMem[pins.addrLines]);
        check("pulse oe", pins.dataOe, 1);
        if (fastMode) begin
          check("fast vpp", pins.vppSel, eps_pkg::VPP_FAST);
          check("fast vcc", pins.vccSel, eps_pkg::VCC_FAST);
        end else begin
          check("prog vpp", pins.vppSel, eps_pkg::VPP_PROG);
        end
      end
    end else if (pulseLen > 0) begin
      check("pulse width", pulseLen, PW + 1);
      pulseCnt++;
      pulseLen = 0;
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      numErrors++;
      endSim();
    end
  end
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic endSim();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A second start at cycle midStart must be ignored while busy
  task automatic run(input logic fast, input logic [14:0] first, input logic [14:0] last,
                     input int midStart);
    int n;
    fastMode = fast;
    pulseCnt = 0;
    readNom = 0;
    readRaised = 0;
    failCnt = 0;
    @(posedge mclk);
    #1;
    cmd = '{start: 1'b1, fast: fast, first: first, last: last};
    @(posedge mclk);
    #1;
    cmd.start = 1'b0;
    check("busy", busy, 1);
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
      if (n == midStart) cmd = '{start: 1'b1, fast: ~fast, first: 15'h0, last: 15'h7fff};
      if (n == midStart + 1) cmd.start = 1'b0;
    end
    check("done", done, 1);
    @(posedge mclk);
    #1;
    check("busy end", busy, 0);
    check("vpp end", pins.vppSel, eps_pkg::VPP_NOM);
    check("sel end", pins.selN, 1);
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic tReset();
    check("rst sel", pins.selN, 1);
    check("rst oe", pins.dataOe, 0);
    check("rst vpp", pins.vppSel, eps_pkg::VPP_NOM);
    check("rst busy", busy, 0);
  endtask
  task automatic tFast();
    expMem[0] = 8'h5a;
    expMem[1] = 8'h00;
    expMem[2] = 8'h3c;
    expMem[3] = 8'hfe;
    needPulses = 8'h01;
    run(1'b1, 15'h0, 15'h3, 0);
    check("pulses", pulseCnt, 4);
    check("final reads", readNom, 4);
    check("fails", failCnt, 0);
    for (int i = 0; i < 4; i++) begin
      check("cell", devU.mem[i], expMem[i]);
      check("inhibited cell", inhU.mem[i], 8'hff);
    end
  endtask
  task automatic tSlow();
    expMem[15'h7ffe] = 8'hc3;
    expMem[15'h7fff] = 8'h18;
    needPulses = 8'h03;
    run(1'b1, 15'h7ffe, 15'h7fff, 300);
    check("pulses", pulseCnt, 6);
    check("verifies", readRaised, 6);
    check("top cell", devU.mem[15'h7fff], 8'h18);
    check("fails", failCnt, 0);
  endtask
  // Cell 3 holds fe; its low bit cannot rise, so every retry fails
  task automatic tFail();
    expMem[3] = 8'h01;
    needPulses = 8'h01;
    run(1'b1, 15'h3, 15'h3, 0);
    check("pulses", pulseCnt, MAXP);
    check("fail pulses", failCnt, 2);
    check("fail addr", firstFail, 3);
    check("sticky", anyFail, 1);
    check("cell", devU.mem[3], 8'h00);
  endtask
  task automatic tInter();
    expMem[5] = 8'h81;
    expMem[6] = 8'h7e;
    needPulses = 8'h02;
    run(1'b0, 15'h5, 15'h6, 0);
    check("pulses", pulseCnt, 6);
    check("verifies", readRaised, 4);
    check("final reads", readNom, 2);
    check("sticky", anyFail, 0);
    check("cell", devU.mem[6], 8'h7e);
  endtask
  initial begin
    nrst = 1'b0;
    cmd = '0;
    byteValid = 1'b0;
    byteIn = 8'h00;
    needPulses = 8'h01;
    fastMode = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    nrst = 1'b1;
    tReset();
    tFast();
    tSlow();
    tFail();
    tInter();
    endSim();
  end
endmodule
